// ===== pkg/lpcg_regs.vh
`ifndef LPCG_REGS_VH
`define LPCG_REGS_VH

// ----------------------------------------
// Register byte offsets in the control block
// ----------------------------------------
`define LPCG_OFF_RUN 12'h100
`define LPCG_OFF_CFG 12'h060
`define LPCG_OFF_SLEEP 12'h110
`define LPCG_OFF_DEEP 12'h120
`define LPCG_OFF_IRQ_STAT 12'h130
`define LPCG_OFF_IRQ_MASK 12'h134
`define LPCG_OFF_FAULT_ADDR 12'h138
`define LPCG_OFF_STATE 12'h13c
`define LPCG_BASE 32'h400fe000
`define LPCG_ADDR_W 12

// ----------------------------------------
// Gate register fields and reset values
// ----------------------------------------
`define LPCG_BIT_AN2 26
`define LPCG_BIT_AN1 25
`define LPCG_BIT_AN0 24
`define LPCG_BIT_HIB 6
`define LPCG_BIT_WDT 3
`define LPCG_GATE_MASK 32'h07000048
`define LPCG_GATE_RESET 32'h00000040
`define LPCG_CFG_AUTO_BIT 27
`define LPCG_CFG_MASK 32'h08000000
`define LPCG_CFG_RESET 32'h00000000

// ----------------------------------------
// Interrupt status bits
// ----------------------------------------
`define LPCG_IRQ_W 2
`define LPCG_IRQ_FAULT 0
`define LPCG_IRQ_MODE 1

// ----------------------------------------
// Power modes and bus answers
// ----------------------------------------
`define LPCG_MODE_RUN 2'h0
`define LPCG_MODE_SLEEP 2'h1
`define LPCG_MODE_DEEP 2'h2
`define LPCG_RESP_OKAY 2'h0
`define LPCG_RESP_SLVERR 2'h2

`endif

// ===== core/lpcg_gate_sel.v
`timescale 1ns/10ps
`default_nettype none
`include "lpcg_regs.vh"

module lpcg_gate_sel (
  input wire aclk,
  input wire aresetn,
  input wire clk_en,
  input wire [1:0] mode,
  input wire auto_gate,
  input wire [31:0] run_gate,
  input wire [31:0] sleep_gate,
  input wire [31:0] deep_gate,
  output reg [31:0] active_gate
);

  reg [31:0] active_next;

  // ----------------------------------------
  // Pick the register that governs this mode
  // ----------------------------------------
  always @* begin
    active_next = run_gate;
    if (auto_gate) begin
      case (mode)
        `LPCG_MODE_SLEEP: active_next = sleep_gate;
        `LPCG_MODE_DEEP: active_next = deep_gate;
        default: active_next = run_gate;
      endcase
    end
  end

  // Registered so enables never glitch
  always @(posedge aclk) begin
    if (!aresetn) begin
      active_gate <= `LPCG_GATE_RESET;
    end else if (clk_en) begin
      active_gate <= active_next & `LPCG_GATE_MASK;
    end
  end

endmodule
`default_nettype wire

// ===== core/lpcg_top.v
// Notes on behaviour
// - A set gate bit clocks its unit; a clear bit stops it.
// - Access to an unclocked unit is answered with a bus fault.
// - Gate bits reset cleared except bit 6; run, sleep and deep registers all reset to 0x40.
// - Run, sleep and deep-sleep registers each hold the same gate bits.
// - Sleep and deep registers apply only while automatic gating is set.
// - Bits 26..24 gate area-net units two, one, zero; reset zero.
// - Bit 6 gates hibernation; resets to one.
// - Bit 3 gates the watchdog; resets zero; unclocked access faults.
// - Reserved bits read zero and ignore writes.
// - Deep-sleep register sits at offset 0x120.
// - Sleep register sits at offset 0x110, same reset value.
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
`include "lpcg_regs.vh"

module lpcg_top #(
  parameter ADDR_W = `LPCG_ADDR_W
) (
  input wire aclk,
  input wire aresetn,
  input wire clk_en,
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire sleep_req,
  input wire deep_req,
  input wire [4:0] unit_access,
  output reg [4:0] unit_fault,
  output reg an2_clk_en,
  output reg an1_clk_en,
  output reg an0_clk_en,
  output reg hib_clk_en,
  output reg wdt_clk_en,
  output reg [1:0] power_mode,
  output reg irq
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function [31:0] merge_wr;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0] strb;
    input [31:0] keep;
    integer i;
    begin
      merge_wr = old_val;
      // Byte lanes follow the strobes; others keep their bits
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          merge_wr[i*8 +: 8] = new_val[i*8 +: 8];
        end
      end
      // Reserved bits forced low so reads never show them
      merge_wr = merge_wr & keep;
    end
  endfunction

  function [4:0] gate_bits;
    input [31:0] g;
    begin
      gate_bits = {g[`LPCG_BIT_AN2], g[`LPCG_BIT_AN1], g[`LPCG_BIT_AN0],
        g[`LPCG_BIT_HIB], g[`LPCG_BIT_WDT]};
    end
  endfunction

  function reg_known;
    input [ADDR_W-1:0] a;
    begin
      case (a)
        `LPCG_OFF_RUN: reg_known = 1'b1;
        `LPCG_OFF_SLEEP: reg_known = 1'b1;
        `LPCG_OFF_DEEP: reg_known = 1'b1;
        `LPCG_OFF_CFG: reg_known = 1'b1;
        `LPCG_OFF_IRQ_STAT: reg_known = 1'b1;
        `LPCG_OFF_IRQ_MASK: reg_known = 1'b1;
        `LPCG_OFF_FAULT_ADDR: reg_known = 1'b1;
        `LPCG_OFF_STATE: reg_known = 1'b1;
        default: reg_known = 1'b0;
      endcase
    end
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  reg [31:0] run_gate_reg;
  reg [31:0] cfg_reg;
  reg [31:0] sleep_gate_reg;
  reg [31:0] deep_gate_reg;
  reg [`LPCG_IRQ_W-1:0] irq_stat_reg;
  reg [`LPCG_IRQ_W-1:0] irq_mask_reg;
  reg [4:0] fault_unit_reg;
  reg [ADDR_W-1:0] aw_addr_reg;
  reg aw_have_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;
  reg w_have_reg;
  reg sleep_s1_reg;
  reg sleep_s2_reg;
  reg deep_s1_reg;
  reg deep_s2_reg;
  reg [4:0] acc_s1_reg;
  reg [4:0] acc_s2_reg;
  reg [1:0] mode_reg;
  reg [1:0] mode_next;

  wire [31:0] active_gate;
  wire [4:0] active_bits;
  wire [4:0] fault_now;
  wire wr_fire;
  wire rd_fire;
  reg wr_err;
  reg rd_err;
  reg [31:0] rd_val;
  reg [`LPCG_IRQ_W-1:0] ev_set;

  // Response waits for both halves, which may come in either order
  assign wr_fire = aw_have_reg && w_have_reg && !s_axi_bvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign active_bits = gate_bits(active_gate);
  // Selector output, so a fault matches the same cycle's enables
  assign fault_now = acc_s2_reg & ~active_bits;

  lpcg_gate_sel u_sel (
    .aclk(aclk),
    .aresetn(aresetn),
    .clk_en(clk_en),
    .mode(mode_reg),
    .auto_gate(cfg_reg[`LPCG_CFG_AUTO_BIT]),
    .run_gate(run_gate_reg),
    .sleep_gate(sleep_gate_reg),
    .deep_gate(deep_gate_reg),
    .active_gate(active_gate)
  );

  // ----------------------------------------
  // Pin synchronisers and power mode
  // ----------------------------------------
  // Two flops per pin; only the second stage is read
  always @(posedge aclk) begin
    if (!aresetn) begin
      sleep_s1_reg <= 1'b0;
      sleep_s2_reg <= 1'b0;
      deep_s1_reg <= 1'b0;
      deep_s2_reg <= 1'b0;
      acc_s1_reg <= 5'h00;
      acc_s2_reg <= 5'h00;
    end else if (clk_en) begin
      sleep_s1_reg <= sleep_req;
      sleep_s2_reg <= sleep_s1_reg;
      deep_s1_reg <= deep_req;
      deep_s2_reg <= deep_s1_reg;
      acc_s1_reg <= unit_access;
      acc_s2_reg <= acc_s1_reg;
    end
  end

  // Deep request wins over a plain sleep request
  always @* begin
    if (deep_s2_reg) begin
      mode_next = `LPCG_MODE_DEEP;
    end else if (sleep_s2_reg) begin
      mode_next = `LPCG_MODE_SLEEP;
    end else begin
      mode_next = `LPCG_MODE_RUN;
    end
  end

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  always @* begin
    rd_err = !reg_known(s_axi_araddr);
    rd_val = 32'h00000000;
    case (s_axi_araddr)
      `LPCG_OFF_RUN: rd_val = run_gate_reg;
      `LPCG_OFF_SLEEP: rd_val = sleep_gate_reg;
      `LPCG_OFF_DEEP: rd_val = deep_gate_reg;
      `LPCG_OFF_CFG: rd_val = cfg_reg;
      `LPCG_OFF_IRQ_STAT: begin
        rd_val[`LPCG_IRQ_W-1:0] = irq_stat_reg;
      end
      `LPCG_OFF_IRQ_MASK: begin
        rd_val[`LPCG_IRQ_W-1:0] = irq_mask_reg;
      end
      `LPCG_OFF_FAULT_ADDR: rd_val = {27'h0000000, fault_unit_reg};
      `LPCG_OFF_STATE: rd_val = {30'h00000000, mode_reg};
      // Unmapped offsets read as zero
      default: rd_val = 32'h00000000;
    endcase
  end

  // Same map check as reads, so both channels agree
  always @* begin
    wr_err = !reg_known(aw_addr_reg);
  end

  // Events: any faulting access, any change of power mode
  always @* begin
    ev_set = {`LPCG_IRQ_W{1'b0}};
    ev_set[`LPCG_IRQ_FAULT] = |fault_now;
    ev_set[`LPCG_IRQ_MODE] = (mode_next != mode_reg);
  end

  // ----------------------------------------
  // AXI4-Lite slave and registers
  // ----------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `LPCG_RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `LPCG_RESP_OKAY;
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      aw_addr_reg <= {ADDR_W{1'b0}};
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      run_gate_reg <= `LPCG_GATE_RESET;
      sleep_gate_reg <= `LPCG_GATE_RESET;
      deep_gate_reg <= `LPCG_GATE_RESET;
      cfg_reg <= `LPCG_CFG_RESET;
      irq_stat_reg <= {`LPCG_IRQ_W{1'b0}};
      irq_mask_reg <= {`LPCG_IRQ_W{1'b0}};
      fault_unit_reg <= 5'h00;
      mode_reg <= `LPCG_MODE_RUN;
    end else if (clk_en) begin
      mode_reg <= mode_next;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_reg <= s_axi_awaddr;
        aw_have_reg <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
        w_have_reg <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      // Set beats clear: a fault in the clearing cycle is kept
      irq_stat_reg <= irq_stat_reg | ev_set;
      fault_unit_reg <= fault_unit_reg | fault_now;
      // Bad offsets still answer, with an error and no write
      if (wr_fire) begin
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_err ? `LPCG_RESP_SLVERR : `LPCG_RESP_OKAY;
        case (aw_addr_reg)
          `LPCG_OFF_RUN: run_gate_reg <= merge_wr(run_gate_reg,
            w_data_reg, w_strb_reg, `LPCG_GATE_MASK);
          `LPCG_OFF_SLEEP: sleep_gate_reg <= merge_wr(sleep_gate_reg,
            w_data_reg, w_strb_reg, `LPCG_GATE_MASK);
          `LPCG_OFF_DEEP: deep_gate_reg <= merge_wr(deep_gate_reg,
            w_data_reg, w_strb_reg, `LPCG_GATE_MASK);
          `LPCG_OFF_CFG: cfg_reg <= merge_wr(cfg_reg,
            w_data_reg, w_strb_reg, `LPCG_CFG_MASK);
          // One clear write serves status and the fault-unit record
          `LPCG_OFF_IRQ_STAT: begin
            if (w_strb_reg[0]) begin
              irq_stat_reg <= (irq_stat_reg &
                ~w_data_reg[`LPCG_IRQ_W-1:0]) | ev_set;
              fault_unit_reg <= (fault_unit_reg & ~w_data_reg[4:0])
                | fault_now;
            end
          end
          `LPCG_OFF_IRQ_MASK: begin
            if (w_strb_reg[0]) begin
              irq_mask_reg <= w_data_reg[`LPCG_IRQ_W-1:0];
            end
          end
          default: begin
          end
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      if (rd_fire) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_val;
        s_axi_rresp <= rd_err ? `LPCG_RESP_SLVERR : `LPCG_RESP_OKAY;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Unit clock enables, faults and interrupt
  // ----------------------------------------
  // Enables come one stage behind the selector; units tolerate it
  always @(posedge aclk) begin
    if (!aresetn) begin
      an2_clk_en <= 1'b0;
      an1_clk_en <= 1'b0;
      an0_clk_en <= 1'b0;
      hib_clk_en <= 1'b1;
      wdt_clk_en <= 1'b0;
      unit_fault <= 5'h00;
      power_mode <= `LPCG_MODE_RUN;
      irq <= 1'b0;
    end else if (clk_en) begin
      {an2_clk_en, an1_clk_en, an0_clk_en, hib_clk_en, wdt_clk_en}
        <= active_bits;
      unit_fault <= fault_now;
      power_mode <= mode_reg;
      irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end

endmodule
`default_nettype wire

// ===== sim/lpcg_checker.sv
`timescale 1ns/10ps
`default_nettype none
`include "lpcg_regs.vh"
module lpcg_checker #(
  parameter ADDR_W = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic [4:0] unit_access,
  input wire logic [4:0] unit_fault,
  input wire logic an2_clk_en,
  input wire logic an1_clk_en,
  input wire logic an0_clk_en,
  input wire logic hib_clk_en,
  input wire logic wdt_clk_en,
  input wire logic [1:0] power_mode
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ------------------------------
  // Gating and bus checks
  // ------------------------------
  // Run mode only: other modes may select another register
  sequence run_wr_s;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready &&
    s_axi_awaddr == `LPCG_OFF_RUN && s_axi_wstrb[0] &&
    power_mode == `LPCG_MODE_RUN;
  endsequence
  gate_apply_a: assert property (run_wr_s |-> ##4
    wdt_clk_en == $past(s_axi_wdata[3], 4))
    else $error("watchdog enable does not follow run write");
  rst_value_a: assert property (disable iff (1'b0) !aresetn |=>
    hib_clk_en && !wdt_clk_en && !an0_clk_en && !an1_clk_en &&
    !an2_clk_en && unit_fault == 5'h00)
    else $error("enables wrong after reset");
  fault_gate_a: assert property ((unit_fault & {an2_clk_en,
    an1_clk_en, an0_clk_en, hib_clk_en, wdt_clk_en}) == 5'h00)
    else $error("fault raised on a clocked unit");
  fault_src_a: assert property ($rose(unit_fault[0]) |->
    $past(unit_access[0], 3))
    else $error("watchdog fault without access");
  mode_legal_a: assert property (power_mode != 2'h3)
    else $error("illegal power mode");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  wr_refuse_a: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  bad_rd_a: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr == 12'h004 |=> s_axi_rvalid &&
    s_axi_rresp == `LPCG_RESP_SLVERR)
    else $error("unmapped read not refused");
endmodule
bind lpcg_top lpcg_checker #(.ADDR_W(ADDR_W)) u_chk (
  .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rresp, .s_axi_rvalid, .unit_access, .unit_fault,
  .an2_clk_en, .an1_clk_en, .an0_clk_en, .hib_clk_en, .wdt_clk_en,
  .power_mode);
`default_nettype wire

// ===== sim/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "lpcg_regs.vh"
module tb_top;
  typedef struct {logic [11:0] a; logic [31:0] w, e;} lpcg_row_t;
  logic aclk = 0, aresetn = 0, sleep_req = 0, deep_req = 0;
  logic ce = 1;
  int b_late = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, d;
  logic [3:0] wstrb = 0;
  logic [4:0] acc = 0;
  logic [1:0] r;
  wire awready, wready, bvalid, arready, rvalid, irq;
  wire an2, an1, an0, hibernation_gate, wdt;
  wire [1:0] bresp, rresp, pmode;
  wire [31:0] rdata;
  wire [4:0] fault;
  wire [4:0] ens = {an2, an1, an0, hibernation_gate, wdt};
  int num_errors = 0, n_compared = 0, cyc = 0;
  lpcg_row_t rows[5] = '{'{12'h100, 32'hffffffff, 32'h07000048},
    '{12'h110, 32'hffffffff, 32'h07000048},
    '{12'h120, 32'h05000008, 32'h05000008},
    '{12'h110, 32'h01000000, 32'h01000000},
    '{12'h100, 32'h00000000, 32'h00000000}};
  always #50 aclk = ~aclk;
  lpcg_top u_dut (.aclk(aclk), .aresetn(aresetn), .clk_en(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .sleep_req(sleep_req), .deep_req(deep_req),
    .unit_access(acc), .unit_fault(fault), .an2_clk_en(an2),
    .an1_clk_en(an1), .an0_clk_en(an0), .hib_clk_en(hibernation_gate),
    .wdt_clk_en(wdt), .power_mode(pmode), .irq(irq));
  // ------------------------------
  // Bus tasks
  // ------------------------------
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(logic [11:0] a, logic [31:0] v, output logic [1:0] rs);
    logic ta, tw;
    ta = 0;
    tw = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= (b_late == 0);
    while (!(ta && tw)) begin
      @(posedge aclk);
      if (!ta && awready === 1'b1) begin
        ta = 1;
        awvalid <= 1'b0;
      end
      if (!tw && wready === 1'b1) begin
        tw = 1;
        wvalid <= 1'b0;
      end
    end
    if (b_late > 0) begin
      repeat (b_late) @(posedge aclk);
      bready <= 1'b1;
      @(posedge aclk);
    end
    while (bvalid !== 1'b1) @(posedge aclk);
    rs = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(logic [11:0] a, output logic [31:0] v,
                    output logic [1:0] rs);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge aclk);
    v = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  task automatic rchk(logic [11:0] a, logic [31:0] e, string nm);
    rd(a, d, r);
    chk(nm, d, e);
  endtask
  task stop_test;
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // A hang costs one error and ends the run
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      num_errors++;
      stop_test;
    end
  end
  // ------------------------------
  // Tests
  // ------------------------------
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("enables", ens, 5'b00010);
    rchk(12'h110, 32'h40, "sleep");
    rchk(12'h120, 32'h40, "deep");
    rchk(12'h100, 32'h40, "run");
    $display("reset test done");
    for (int i = 0; i < 5; i++) begin
      wr(rows[i].a, rows[i].w, r);
      rchk(rows[i].a, rows[i].e, "gate reg");
    end
    repeat (3) @(posedge aclk);
    chk("enables", ens, 5'b00000);
    $display("register rows done");
    acc <= 5'b00001;
    repeat (5) @(posedge aclk);
    chk("fault", fault, 5'b00001);
    chk("irq masked", irq, 1'b0);
    rchk(12'h138, 32'h1, "fault unit");
    wr(12'h134, 32'h1, r);
    repeat (2) @(posedge aclk);
    chk("irq", irq, 1'b1);
    acc <= 5'b00000;
    repeat (5) @(posedge aclk);
    wr(12'h130, 32'h1, r);
    repeat (2) @(posedge aclk);
    chk("irq clear", irq, 1'b0);
    rchk(12'h138, 32'h0, "fault unit clear");
    wr(12'h100, 32'h48, r);
    repeat (3) @(posedge aclk);
    chk("enables", ens, 5'b00011);
    acc <= 5'b00001;
    repeat (5) @(posedge aclk);
    chk("fault", fault, 5'b00000);
    acc <= 5'b00000;
    $display("fault test done");
    rd(12'h004, d, r);
    chk("rresp", r, `LPCG_RESP_SLVERR);
    chk("rdata", d, 32'h0);
    wr(12'h008, 32'h1, r);
    chk("bresp", r, `LPCG_RESP_SLVERR);
    b_late = 3;
    wr(12'h134, 32'h1, r);
    b_late = 0;
    chk("late bresp", r, `LPCG_RESP_OKAY);
    $display("unmapped test done");
    sleep_req <= 1'b1;
    repeat (6) @(posedge aclk);
    chk("mode", pmode, `LPCG_MODE_SLEEP);
    chk("enables", ens, 5'b00011);
    wr(12'h060, 32'h08000000, r);
    repeat (3) @(posedge aclk);
    chk("enables", ens, 5'b00100);
    deep_req <= 1'b1;
    repeat (6) @(posedge aclk);
    chk("mode", pmode, `LPCG_MODE_DEEP);
    chk("enables", ens, 5'b10101);
    rchk(12'h13c, 32'h2, "state");
    // Frozen by the clock enable: pins unseen until it returns
    ce <= 1'b0;
    sleep_req <= 1'b0;
    deep_req <= 1'b0;
    repeat (6) @(posedge aclk);
    chk("frozen mode", pmode, `LPCG_MODE_DEEP);
    chk("frozen enables", ens, 5'b10101);
    ce <= 1'b1;
    repeat (6) @(posedge aclk);
    chk("mode", pmode, `LPCG_MODE_RUN);
    chk("enables", ens, 5'b00011);
    rchk(12'h130, 32'h2, "mode event");
    $display("mode test done");
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("enables", ens, 5'b00010);
    $display("second reset done");
    stop_test;
  end
endmodule
`default_nettype wire
